// ### design/hipc_pkg.sv
package hipc_pkg;

    // ************************************************************
    // configuration
    // ************************************************************
    localparam logic HAS_SUP = 1'b1;
    localparam logic HAS_OVF = 1'b1;
    localparam logic HAS_USER = 1'b1;
    localparam int EV_CODES = 16;
    localparam logic [31:0] CNT_IMPL = 32'hFFFF_FFFD;
    localparam logic [31:0] SEL_IMPL = 32'hFFFF_FFF8;
    localparam logic [31:0] CNTEN_RST = 32'h0000_0000;
    localparam logic [15:0] ENA_RST = 16'h0000;

    // ************************************************************
    // register numbers
    // ************************************************************
    localparam logic [11:0] A_SIE = 12'h104;
    localparam logic [11:0] A_SIP = 12'h144;
    localparam logic [11:0] A_MIE = 12'h304;
    localparam logic [11:0] A_MIP = 12'h344;
    localparam logic [11:0] A_CNTEN = 12'h306;
    localparam logic [11:0] A_MCNT_LO = 12'hB00;
    localparam logic [11:0] A_MCNT_HI = 12'hB80;
    localparam logic [11:0] A_USH_LO = 12'hC00;
    localparam logic [11:0] A_USH_HI = 12'hC80;
    localparam logic [11:0] A_SEL_LO = 12'h320;
    localparam logic [11:0] A_SEL_HI = 12'h720;

    // ************************************************************
    // pending and enable bit positions
    // ************************************************************
    localparam int B_S_SW = 1;
    localparam int B_M_SW = 3;
    localparam int B_S_TMR = 5;
    localparam int B_M_TMR = 7;
    localparam int B_S_EXT = 9;
    localparam int B_M_EXT = 11;
    localparam int B_LCOF = 13;
    localparam logic [15:0] ENA_WR = 16'h2AAA;
    localparam logic [15:0] PEND_WR = 16'h2222;
    localparam logic [15:0] SPEND_WR = 16'h2002;
    localparam logic [15:0] SENA_WR = 16'h2222;
    localparam logic [15:0] SUP_BITS = 16'h0222;
    localparam logic [15:0] OVF_BITS = 16'h2000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        HIPC_OP_READ = 2'b00,
        HIPC_OP_WRITE = 2'b01,
        HIPC_OP_SET = 2'b10,
        HIPC_OP_CLEAR = 2'b11
    } hipc_op_e;

    typedef enum logic [1:0] {
        HIPC_PRIV_U = 2'b00,
        HIPC_PRIV_S = 2'b01,
        HIPC_PRIV_M = 2'b11
    } hipc_priv_e;

    typedef struct packed {
        logic m_ext;
        logic m_sw;
        logic m_tmr;
        logic s_ext;
        logic s_sw_set;
    } hipc_irq_in_s;

    typedef struct packed {
        logic [31:0][63:0] cnt;
        logic [31:0][7:0] sel_code;
        logic [31:0] sel_of;
        logic [15:0] ena;
        logic s_sw_pend;
        logic s_tmr_pend;
        logic s_ext_latch;
        logic ovf_pend;
        logic [31:0] cnt_en;
        logic [31:0] rdata;
        logic ack;
        logic illegal;
        logic take;
        logic [3:0] cause;
    } hipc_state_s;

    // ************************************************************
    // functions
    // ************************************************************
    // read-modify-write result of an access
    function automatic logic [31:0] rmw(input hipc_op_e op, input logic [31:0] old, input logic [31:0] src);
        case (op)
            HIPC_OP_WRITE: rmw = src;
            HIPC_OP_SET: rmw = old | src;
            HIPC_OP_CLEAR: rmw = old & ~src;
            default: rmw = old;
        endcase
    endfunction

    // register number falls in a 32-entry group
    function automatic logic in_grp(input logic [11:0] addr, input logic [11:0] base);
        in_grp = (addr[11:5] == base[11:5]);
    endfunction

endpackage

// ### design/hipc_top.sv
module hipc_top import hipc_pkg::*; (
    input wire logic mclk,                      // core clock
    input wire logic rst_n,                     // async reset, active low
    input wire logic csr_req,                   // access request, one cycle
    input wire hipc_op_e csr_op,                // read, write, set, clear
    input wire logic [11:0] csr_addr,           // register number
    input wire logic [31:0] csr_wdata,          // source operand
    input wire hipc_priv_e priv,                // current privilege mode
    input wire logic glob_mie,                  // machine global enable
    input wire logic [15:0] irq_deleg,          // interrupt delegation bits
    input wire hipc_irq_in_s irq_in,            // platform interrupt lines
    input wire logic [63:0] wall_time,          // memory-mapped timer value
    input wire logic [1:0] retire_cnt,          // instructions retired now
    input wire logic [EV_CODES-1:0] event_hit,  // event occurrences by code
    output logic [31:0] csr_rdata,              // read data
    output logic csr_ack,                       // access answered, pulse
    output logic csr_illegal,                   // illegal-instruction, pulse
    output logic irq_take,                      // interrupt trap requested
    output logic [3:0] irq_cause                // cause of chosen interrupt
);

    // ************************************************************
    // state
    // ************************************************************
    hipc_state_s st_r;
    hipc_state_s st_nxt;

    // ************************************************************
    // decode
    // ************************************************************
    logic [4:0] idx;
    logic hi_half;
    logic is_wr;
    logic g_mcnt;
    logic g_ush;
    logic g_sel;
    logic [1:0] need_priv;

    // address fields and group hits
    assign idx = csr_addr[4:0];
    // selector high halves differ from low ones at bit 10, counters at bit 7
    assign hi_half = in_grp(csr_addr, A_SEL_HI) || csr_addr[7];
    assign is_wr = (csr_op != HIPC_OP_READ);
    assign g_mcnt = in_grp(csr_addr, A_MCNT_LO) || in_grp(csr_addr, A_MCNT_HI);
    assign g_ush = in_grp(csr_addr, A_USH_LO) || in_grp(csr_addr, A_USH_HI);
    assign g_sel = in_grp(csr_addr, A_SEL_LO) || (HAS_OVF && in_grp(csr_addr, A_SEL_HI));
    assign need_priv = csr_addr[9:8];

    // ************************************************************
    // pending views
    // ************************************************************
    logic [15:0] pend_rd;
    logic [15:0] pend_sw;
    logic [15:0] ena_rd;
    logic [15:0] fire;
    logic glob_ok;

    // pending bits as read and as stored
    always_comb begin
        pend_rd = 16'h0000;
        // machine sources are read straight from the lines
        pend_rd[B_M_EXT] = irq_in.m_ext;
        pend_rd[B_M_SW] = irq_in.m_sw;
        pend_rd[B_M_TMR] = irq_in.m_tmr;
        // external line only widens the view, never the latch
        pend_rd[B_S_EXT] = HAS_SUP & (st_r.s_ext_latch | irq_in.s_ext);
        pend_rd[B_S_SW] = HAS_SUP & st_r.s_sw_pend;
        pend_rd[B_S_TMR] = HAS_SUP & st_r.s_tmr_pend;
        pend_rd[B_LCOF] = HAS_OVF & st_r.ovf_pend;
        // old value seen by set and clear operations
        pend_sw = pend_rd;
        pend_sw[B_S_EXT] = HAS_SUP & st_r.s_ext_latch;
        ena_rd = st_r.ena & ENA_WR;
        if (!HAS_OVF) begin
            ena_rd = ena_rd & ~OVF_BITS;
        end
    end

    // trap condition toward machine mode
    assign glob_ok = (priv != HIPC_PRIV_M) || glob_mie;
    assign fire = pend_rd & ena_rd & ~irq_deleg;

    // ************************************************************
    // read mux and legality
    // ************************************************************
    logic [31:0] rd_val;
    logic [31:0] rd_old;
    logic legal;
    logic [63:0] cnt_full;

    // counter value selected by index
    always_comb begin
        if (idx == 5'h01) begin
            cnt_full = wall_time;
        end else if (CNT_IMPL[idx]) begin
            cnt_full = st_r.cnt[idx];
        end else begin
            cnt_full = 64'h0000_0000_0000_0000;
        end
    end

    // register read and access check
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_old = 32'h0000_0000;
        legal = 1'b1;
        if (csr_addr == A_MIP) begin
            rd_val = {16'h0000, pend_rd};
            rd_old = {16'h0000, pend_sw};
        end else if (csr_addr == A_MIE) begin
            rd_val = {16'h0000, ena_rd};
            rd_old = rd_val;
        end else if (HAS_SUP && csr_addr == A_SIP) begin
            rd_val = {16'h0000, pend_rd & irq_deleg};
            rd_old = {16'h0000, pend_sw & irq_deleg};
        end else if (HAS_SUP && csr_addr == A_SIE) begin
            rd_val = {16'h0000, ena_rd & irq_deleg};
            rd_old = rd_val;
        end else if (HAS_USER && csr_addr == A_CNTEN) begin
            rd_val = st_r.cnt_en;
            rd_old = rd_val;
        end else if (g_mcnt && idx != 5'h01) begin
            rd_val = hi_half ? cnt_full[63:32] : cnt_full[31:0];
            rd_old = rd_val;
        end else if (g_ush) begin
            rd_val = hi_half ? cnt_full[63:32] : cnt_full[31:0];
            rd_old = rd_val;
            if (is_wr) begin
                legal = 1'b0;
            end
            if (priv != HIPC_PRIV_M && !st_r.cnt_en[idx]) begin
                legal = 1'b0;
            end
        end else if (g_sel && idx >= 5'h03) begin
            if (!SEL_IMPL[idx]) begin
                rd_val = 32'h0000_0000;
            end else if (hi_half) begin
                rd_val = {st_r.sel_of[idx] & HAS_OVF, 31'h0000_0000};
            end else begin
                rd_val = {24'h00_0000, st_r.sel_code[idx]};
            end
            rd_old = rd_val;
        end else begin
            legal = 1'b0;
        end
        // lower modes reach only registers of their own level or below
        if (priv < need_priv) begin
            legal = 1'b0;
        end
        if (priv == HIPC_PRIV_U && HAS_SUP && g_ush) begin
            legal = 1'b0;
        end
    end

    // ************************************************************
    // write value
    // ************************************************************
    logic [31:0] wv;
    logic commit;

    // the write lands at the end of the accessing cycle
    assign wv = rmw(csr_op, rd_old, csr_wdata);
    assign commit = csr_req && is_wr && legal;

    // ************************************************************
    // counter arithmetic
    // ************************************************************
    logic [31:0][1:0] inc;
    logic [31:0][64:0] sum;
    logic [31:0] of_set;

    // increment per counter and overflow carry
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            inc[i] = 2'b00;
            if (i == 0) begin
                inc[i] = 2'b01;
            end else if (i == 2) begin
                inc[i] = retire_cnt;
            end else if (i >= 3 && SEL_IMPL[i]) begin
                if (st_r.sel_code[i] != 8'h00 && st_r.sel_code[i] < 8'(EV_CODES)) begin
                    inc[i] = {1'b0, event_hit[st_r.sel_code[i][3:0]]};
                end
            end
            sum[i] = {1'b0, st_r.cnt[i]} + {63'h0, inc[i]};
            of_set[i] = HAS_OVF & SEL_IMPL[i] & sum[i][64];
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    logic [15:0] pend_new;
    logic [15:0] pend_mask;
    logic [15:0] ena_mask;

    // masks of bits each view may write
    always_comb begin
        pend_mask = 16'h0000;
        ena_mask = 16'h0000;
        if (csr_addr == A_MIP) begin
            pend_mask = PEND_WR;
        end else if (csr_addr == A_SIP) begin
            pend_mask = SPEND_WR & irq_deleg;
        end
        if (csr_addr == A_MIE) begin
            ena_mask = ENA_WR;
        end else if (csr_addr == A_SIE) begin
            ena_mask = SENA_WR & irq_deleg;
        end
        if (!HAS_SUP) begin
            pend_mask = pend_mask & ~SUP_BITS;
            ena_mask = ena_mask & ~SUP_BITS;
        end
        if (!HAS_OVF) begin
            pend_mask = pend_mask & ~OVF_BITS;
            ena_mask = ena_mask & ~OVF_BITS;
        end
        pend_new = (pend_sw & ~pend_mask) | (wv[15:0] & pend_mask);
    end

    // fill the next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = csr_req;
        st_nxt.illegal = csr_req && !legal;
        st_nxt.rdata = (csr_req && legal) ? rd_val : 32'h0000_0000;

        // pending latches, hardware set wins over software clear
        if (commit) begin
            st_nxt.s_ext_latch = pend_new[B_S_EXT];
            st_nxt.s_tmr_pend = pend_new[B_S_TMR];
            st_nxt.s_sw_pend = pend_new[B_S_SW];
            st_nxt.ovf_pend = pend_new[B_LCOF];
            st_nxt.ena = (st_r.ena & ~ena_mask) | (wv[15:0] & ena_mask);
        end
        // controller request lands even in a clearing cycle
        if (HAS_SUP && irq_in.s_sw_set) begin
            st_nxt.s_sw_pend = 1'b1;
        end
        // a wrap of any event counter (index 3 and up) raises overflow pending
        if (HAS_OVF && (|of_set)) begin
            st_nxt.ovf_pend = 1'b1;
        end

        // counter enable touches no counter
        if (commit && HAS_USER && csr_addr == A_CNTEN) begin
            st_nxt.cnt_en = wv;
        end

        // counters keep running; a write replaces one half and skips the step
        for (int i = 0; i < 32; i++) begin
            st_nxt.cnt[i] = sum[i][63:0] & {64{CNT_IMPL[i]}};
            if (commit && g_mcnt && idx == 5'(i) && CNT_IMPL[i]) begin
                if (hi_half) begin
                    st_nxt.cnt[i] = {wv, st_r.cnt[i][31:0]};
                end else begin
                    st_nxt.cnt[i] = {st_r.cnt[i][63:32], wv};
                end
            end
            if (of_set[i]) begin
                st_nxt.sel_of[i] = 1'b1;
            end
            if (commit && g_sel && idx == 5'(i) && SEL_IMPL[i]) begin
                if (hi_half) begin
                    st_nxt.sel_of[i] = wv[31] | of_set[i];
                end else if (wv < 32'(EV_CODES)) begin
                    st_nxt.sel_code[i] = wv[7:0];
                end else begin
                    st_nxt.sel_code[i] = 8'h00;
                end
            end
            if (!SEL_IMPL[i]) begin
                st_nxt.sel_code[i] = 8'h00;
                st_nxt.sel_of[i] = 1'b0;
            end
        end

        // fixed service priority among interrupts to machine mode
        // no cause is shown while the global gate holds the trap back
        st_nxt.take = glob_ok && (|fire);
        if (!glob_ok) begin
            st_nxt.cause = 4'h0;
        end else if (fire[B_M_EXT]) begin
            st_nxt.cause = 4'(B_M_EXT);
        end else if (fire[B_M_SW]) begin
            st_nxt.cause = 4'(B_M_SW);
        end else if (fire[B_M_TMR]) begin
            st_nxt.cause = 4'(B_M_TMR);
        end else if (fire[B_S_EXT]) begin
            st_nxt.cause = 4'(B_S_EXT);
        end else if (fire[B_S_SW]) begin
            st_nxt.cause = 4'(B_S_SW);
        end else if (fire[B_S_TMR]) begin
            st_nxt.cause = 4'(B_S_TMR);
        end else if (fire[B_LCOF]) begin
            st_nxt.cause = 4'(B_LCOF);
        end else begin
            st_nxt.cause = 4'h0;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // whole state in one register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ena <= ENA_RST;
            st_r.cnt_en <= CNTEN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign csr_rdata = st_r.rdata;
    assign csr_ack = st_r.ack;
    assign csr_illegal = st_r.illegal;
    assign irq_take = st_r.take;
    assign irq_cause = st_r.cause;

endmodule

// ### sim/hipc_monitor.sv
module hipc_monitor import hipc_pkg::*; (
    input wire logic mclk, // core clock
    input wire logic rst_n, // reset, active low
    input wire logic csr_req, // access request
    input wire hipc_op_e csr_op, // operation
    input wire logic [11:0] csr_addr, // register number
    input wire logic [31:0] csr_wdata, // source operand
    input wire hipc_priv_e priv, // current mode
    input wire logic glob_mie, // machine global enable
    input wire logic [15:0] irq_deleg, // delegation bits
    input wire hipc_irq_in_s irq_in, // interrupt lines
    input wire logic [63:0] wall_time, // timer value
    input wire logic [1:0] retire_cnt, // retired this cycle
    input wire logic [EV_CODES-1:0] event_hit, // event occurrences
    input wire logic [31:0] csr_rdata, // read data
    input wire logic csr_ack, // answer pulse
    input wire logic csr_illegal, // refusal pulse
    input wire logic irq_take, // trap request
    input wire logic [3:0] irq_cause // chosen cause
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] deleg_q;

    // delegation seen by the trap decision of the previous cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            deleg_q <= 16'h0000;
        end else begin
            deleg_q <= irq_deleg;
        end
    end

    // ************************************************************
    // access and interrupt properties
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_request;
        csr_req;
    endsequence
    sequence s_shadow_req;
        csr_req && csr_addr[11:8] == 4'hC;
    endsequence
    a_ack_after_req: assert property (s_request |=> csr_ack)
        else $error("no answer one cycle after request");
    a_no_stray_ack: assert property (!csr_req |=> !csr_ack && csr_rdata == 32'h0000_0000)
        else $error("answer or data without request");
    a_illegal_no_data: assert property (csr_illegal |-> csr_ack && csr_rdata == 32'h0000_0000)
        else $error("refused access returned data");
    a_shadow_read_only: assert property (s_shadow_req and csr_op != HIPC_OP_READ |=> csr_illegal)
        else $error("write to shadow accepted");
    a_user_shadow_gate: assert property (s_shadow_req and priv == HIPC_PRIV_U |=> csr_illegal)
        else $error("shadow reached from user mode");
    a_time_slot_unmapped: assert property (csr_req && csr_addr == 12'hB01 |=> csr_illegal)
        else $error("machine counter slot one accepted");
    a_deleg_masked: assert property (irq_take |-> !deleg_q[irq_cause])
        else $error("delegated interrupt fired");
    a_global_gate: assert property (priv == HIPC_PRIV_M && !glob_mie |=> !irq_take)
        else $error("trap while machine interrupts disabled");
    a_cause_legal: assert property (irq_take |-> irq_cause inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD})
        else $error("trap with undefined cause");
    a_idle_cause: assert property (!irq_take |-> irq_cause == 4'h0)
        else $error("cause without trap");
endmodule
bind hipc_top hipc_monitor u_mon (.mclk, .rst_n, .csr_req, .csr_op, .csr_addr, .csr_wdata, .priv, .glob_mie,
    .irq_deleg, .irq_in, .wall_time, .retire_cnt, .event_hit, .csr_rdata, .csr_ack, .csr_illegal, .irq_take,
    .irq_cause);

// ### sim/hipc_pipe_model.sv
module hipc_pipe_model import hipc_pkg::*; (
    input wire logic mclk, // core clock
    input wire logic [31:0] csr_rdata, // read data
    input wire logic csr_ack, // answer pulse
    input wire logic csr_illegal, // refusal pulse
    output logic csr_req, // request pulse
    output hipc_op_e csr_op, // operation
    output logic [11:0] csr_addr, // register number
    output logic [31:0] csr_wdata // source operand
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle pipeline
    initial begin
        csr_req = 1'b0;
        csr_op = HIPC_OP_READ;
        csr_addr = 12'h000;
        csr_wdata = 32'h0000_0000;
    end

    // one access: answer read on the next falling edge while it stands, then one idle cycle
    task automatic access(input hipc_op_e op, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic ill);
        csr_req = 1'b1;
        csr_op = op;
        csr_addr = a;
        csr_wdata = d;
        @(negedge mclk);
        rd = (csr_ack === 1'b1) ? csr_rdata : 32'hXXXX_XXXX;
        ill = (csr_ack === 1'b1) ? csr_illegal : 1'bX;
        csr_req = 1'b0;
        csr_addr = ~a; // stale operands inverted once released
        csr_wdata = ~d;
        @(negedge mclk);
    endtask
endmodule

// ### sim/tb_hipc_top.sv
module tb_hipc_top import hipc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic csr_req, csr_ack, csr_illegal, irq_take, ill;
    hipc_op_e csr_op;
    logic [11:0] csr_addr;
    logic [31:0] csr_wdata, csr_rdata, rdv, v;
    hipc_priv_e priv = HIPC_PRIV_M;
    logic glob_mie = 1'b0;
    logic [15:0] irq_deleg = 16'h0000;
    hipc_irq_in_s irq_in = 5'h00;
    logic [63:0] wall_time = 64'h1234_5678_9ABC_DEF0;
    logic [1:0] retire_cnt = 2'h3;
    logic [EV_CODES-1:0] event_hit = 16'hFFFF;
    logic [3:0] irq_cause;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    localparam logic [3:0] PRIO [7] = '{4'hB, 4'h3, 4'h7, 4'h9, 4'h1, 4'h5, 4'hD};

    hipc_top dut (.mclk, .rst_n, .csr_req, .csr_op, .csr_addr, .csr_wdata, .priv, .glob_mie, .irq_deleg, .irq_in,
        .wall_time, .retire_cnt, .event_hit, .csr_rdata, .csr_ack, .csr_illegal, .irq_take, .irq_cause);
    hipc_pipe_model pipe (.mclk, .csr_rdata, .csr_ack, .csr_illegal, .csr_req, .csr_op, .csr_addr, .csr_wdata);

    // ************************************************************
    // shared helpers
    // ************************************************************
    always #25 mclk = ~mclk;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input hipc_op_e op, input logic [11:0] a, input logic [31:0] d);
        pipe.access(op, a, d, rdv, ill);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        acc(HIPC_OP_READ, a, 32'h0000_0000);
        chk({31'h0, ill, rdv}, {32'h0, exp});
    endtask
    task automatic illchk(input hipc_op_e op, input logic [11:0] a);
        acc(op, a, 32'h0000_0001);
        chk({63'h0, ill}, 64'h1);
    endtask
    task automatic wait_irq(input logic [4:0] exp);
        repeat (2) @(negedge mclk);
        chk({59'h0, irq_take, irq_cause}, {59'h0, exp});
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_sei();
        irq_in.s_ext = 1'b1;
        rdchk(A_MIP, 32'h0000_0200);
        acc(HIPC_OP_SET, A_MIP, 32'h0000_0000);
        irq_in.s_ext = 1'b0;
        rdchk(A_MIP, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_0200);
        rdchk(A_MIP, 32'h0000_0200);
        irq_in.s_ext = 1'b1;
        acc(HIPC_OP_CLEAR, A_MIP, 32'h0000_0200);
        rdchk(A_MIP, 32'h0000_0200);
        irq_in.s_ext = 1'b0;
        rdchk(A_MIP, 32'h0000_0000);
    endtask
    task automatic t_soft();
        acc(HIPC_OP_WRITE, A_MIP, 32'hFFFF_FFFF);
        rdchk(A_MIP, {16'h0, PEND_WR});
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_0000);
        irq_in.s_sw_set = 1'b1;
        @(negedge mclk);
        irq_in.s_sw_set = 1'b0;
        rdchk(A_MIP, 32'h0000_0002);
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_0000);
    endtask
    task automatic t_prio();
        glob_mie = 1'b1;
        acc(HIPC_OP_WRITE, A_MIE, {16'h0, ENA_WR});
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_2022);
        irq_in = 5'h1E;
        for (int i = 0; i < 7; i++) begin
            wait_irq({1'b1, PRIO[i]});
            case (i)
                0: irq_in.m_ext = 1'b0;
                1: irq_in.m_sw = 1'b0;
                2: irq_in.m_tmr = 1'b0;
                3: irq_in.s_ext = 1'b0;
                4: acc(HIPC_OP_CLEAR, A_MIP, 32'h0000_0002);
                5: acc(HIPC_OP_CLEAR, A_MIP, 32'h0000_0020);
                default: ;
            endcase
        end
        irq_deleg = 16'h2000;
        wait_irq(5'h00);
        irq_deleg = 16'h0000;
        glob_mie = 1'b0;
        wait_irq(5'h00);
        priv = HIPC_PRIV_S;
        wait_irq(5'h1D);
        priv = HIPC_PRIV_M;
        acc(HIPC_OP_WRITE, A_MIE, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_0000);
    endtask
    task automatic t_sup();
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_0002);
        rdchk(A_SIP, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_SIE, 32'h0000_2222);
        rdchk(A_MIE, 32'h0000_0000);
        irq_deleg = 16'h0002;
        rdchk(A_SIP, 32'h0000_0002);
        acc(HIPC_OP_WRITE, A_SIE, 32'h0000_2222);
        rdchk(A_MIE, 32'h0000_0002);
        irq_deleg = 16'h0000;
        acc(HIPC_OP_WRITE, A_MIE, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_0000);
    endtask
    task automatic t_cnt();
        acc(HIPC_OP_WRITE, A_MCNT_LO, 32'hFFFF_FFF0);
        rdchk(A_MCNT_LO, 32'hFFFF_FFF1);
        acc(HIPC_OP_WRITE, A_MCNT_HI, 32'h0000_0005);
        acc(HIPC_OP_WRITE, A_MCNT_LO, 32'hFFFF_FFFE);
        rdchk(A_MCNT_HI, 32'h0000_0005);
        rdchk(A_MCNT_HI, 32'h0000_0006);
        acc(HIPC_OP_WRITE, A_MCNT_LO, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_CNTEN, 32'hFFFF_FFFF);
        rdchk(A_MCNT_LO, 32'h0000_0003);
        rdchk(A_CNTEN, 32'hFFFF_FFFF);
        acc(HIPC_OP_WRITE, A_MCNT_LO + 12'h002, 32'h0000_0000);
        rdchk(A_MCNT_LO + 12'h002, 32'h0000_0003);
        acc(HIPC_OP_WRITE, A_SEL_LO + 12'h003, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_MCNT_LO + 12'h003, 32'h0000_0007);
        rdchk(A_MCNT_LO + 12'h003, 32'h0000_0007);
        acc(HIPC_OP_WRITE, A_SEL_LO + 12'h003, 32'h0000_0005);
        acc(HIPC_OP_WRITE, A_MCNT_LO + 12'h003, 32'h0000_0000);
        rdchk(A_MCNT_LO + 12'h003, 32'h0000_0001);
        acc(HIPC_OP_WRITE, A_SEL_LO + 12'h003, 32'h0000_0020);
        rdchk(A_SEL_LO + 12'h003, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_SEL_LO + 12'h003, 32'h0000_0005);
        acc(HIPC_OP_WRITE, A_MCNT_HI + 12'h003, 32'hFFFF_FFFF);
        acc(HIPC_OP_WRITE, A_MCNT_LO + 12'h003, 32'hFFFF_FFFF);
        rdchk(A_SEL_HI + 12'h003, 32'h8000_0000);
        rdchk(A_MIP, 32'h0000_2000);
        acc(HIPC_OP_WRITE, A_SEL_HI + 12'h003, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_SEL_LO + 12'h003, 32'h0000_0000);
        acc(HIPC_OP_WRITE, A_MIP, 32'h0000_0000);
    endtask
    task automatic t_shadow();
        acc(HIPC_OP_WRITE, A_CNTEN, 32'h0000_0000);
        priv = HIPC_PRIV_S;
        illchk(HIPC_OP_READ, A_USH_LO);
        priv = HIPC_PRIV_M;
        acc(HIPC_OP_WRITE, A_CNTEN, 32'h0000_0001);
        priv = HIPC_PRIV_S;
        acc(HIPC_OP_READ, A_USH_LO, 32'h0000_0000);
        v = rdv;
        chk({63'h0, ill}, 64'h0);
        priv = HIPC_PRIV_M;
        rdchk(A_MCNT_LO, v + 32'h0000_0002);
        priv = HIPC_PRIV_U;
        illchk(HIPC_OP_READ, A_USH_LO);
        priv = HIPC_PRIV_M;
        illchk(HIPC_OP_WRITE, A_USH_LO);
        illchk(HIPC_OP_READ, A_MCNT_LO + 12'h001);
        illchk(HIPC_OP_READ, A_SEL_LO);
        rdchk(A_USH_LO + 12'h001, wall_time[31:0]);
        rdchk(A_USH_HI + 12'h001, wall_time[63:32]);
    endtask

    // ************************************************************
    // run control
    // ************************************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            final_report();
        end
    end

    // reset then scenarios in turn
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        rdchk(A_CNTEN, CNTEN_RST);
        t_sei();
        t_soft();
        t_prio();
        t_sup();
        t_cnt();
        t_shadow();
        final_report();
    end
endmodule
